/* File: src/smbc_cfg.svh */
`ifndef SMBC_CFG_SVH
`define SMBC_CFG_SVH

// Software register offsets
`define SMBC_OFF_CTRL    8'h00
`define SMBC_OFF_IFCFG   8'h04
`define SMBC_OFF_TIMING  8'h08
`define SMBC_OFF_BURST   8'h0C
`define SMBC_OFF_WDOG    8'h10
`define SMBC_OFF_SHADOW  8'h14

// Control register bit positions
`define SMBC_CTRL_START  0
`define SMBC_CTRL_SEL    1
`define SMBC_CTRL_ARM    3
`define SMBC_CTRL_CLR    4

// Reset values of the interface configuration and the watchdog limit
`define SMBC_RST_ALT     2'h3
`define SMBC_RST_ALW     2'h1
`define SMBC_RST_SCHEME  3'h3
`define SMBC_RST_WDOG    16'hFFFF

// Values the sequencer derives itself, plus the sync interface code and burst limit it checks
`define SMBC_BASE_16     8'h01
`define SMBC_BASE_CF     8'h00
`define SMBC_SPLIT_16    8'h09
`define SMBC_SPLIT_CF    8'h08
`define SMBC_ALW_SYNC    8'h01
`define SMBC_IFACE_SYNC  3'h4
`define SMBC_BURST_MAX   6'h20

`endif

/* File: src/smbc_pkg.sv */
package smbc_pkg;

  typedef enum logic [3:0] {
    F_IFACE    = 4'h0,
    F_BASE     = 4'h1,
    F_SPLIT    = 4'h2,
    F_ALT      = 4'h3,
    F_ALW      = 4'h4,
    F_SCHEME   = 4'h5,
    F_MEMTYPE  = 4'h6,
    F_FIRST    = 4'h7,
    F_NEXT     = 4'h8,
    F_SYNC_RD  = 4'h9,
    F_SYNC_WR  = 4'hA,
    F_SYNC_EN  = 4'hB
  } smbc_field_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_WAIT  = 3'h1,
    S_WRITE = 3'h2,
    S_GAP   = 3'h3,
    S_DONE  = 3'h4
  } smbc_state_t;

  typedef struct packed {
    logic [2:0] iface;
    logic [2:0] mem_type;
    logic       sync_en;
    logic       cf_card;
    logic [1:0] latch_setup_hold_field;
    logic [1:0] latch_strobe_width_field;
    logic [2:0] scheme;
  } smbc_if_cfg_t;

  typedef struct packed {
    logic [7:0] first_delay;
    logic [7:0] next_delay;
    logic [3:0] sync_rd_lat;
    logic [3:0] sync_wr_lat;
  } smbc_timing_t;

  typedef struct packed {
    logic        wr;
    logic [1:0]  cs;
    smbc_field_t field;
    logic [7:0]  value;
  } smbc_cfg_wr_t;

endpackage

/* File: src/smbc_shadow_mem.sv */
`timescale 1ns/10ps
module smbc_shadow_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("smbc_shadow_mem: bad size");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_d;

  always_comb
  begin
    rd_d = mem_q[rd_addr];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
      rd_data <= '0;
    end
    else
    begin
      if (wr_en)
        mem_q[wr_addr] <= wr_data;
      rd_data <= rd_d;
    end
  end
endmodule

/* File: src/smbc_wdog.sv */
`timescale 1ns/10ps
module smbc_wdog #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Control
  input  wire logic             arm,
  input  wire logic [WIDTH-1:0] limit,
  input  wire logic             xfer_busy,
  // Expiry
  output logic                  fire
);
  initial
  begin
    if (WIDTH < 2)
      $error("smbc_wdog: WIDTH too small");
  end

  logic             armed_q;
  logic             armed_d;
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             fire_d;

  // The device waits forever for ready; this bounds that wait
  always_comb
  begin
    armed_d = armed_q;
    cnt_d   = cnt_q;
    fire_d  = 1'b0;
    if (arm)
    begin
      armed_d = 1'b1;
      cnt_d   = '0;
    end
    else if (armed_q)
    begin
      // A zero-wait access ends at once and never trips the limit
      if (!xfer_busy)
        armed_d = 1'b0;
      else if (cnt_q == limit)
      begin
        armed_d = 1'b0;
        fire_d  = 1'b1;
      end
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      armed_q <= 1'b0;
      cnt_q   <= '0;
      fire    <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      cnt_q   <= cnt_d;
      fire    <= fire_d;
    end
  end
endmodule

/* File: src/smbc_host.sv */
`timescale 1ns/10ps
`include "smbc_cfg.svh"
// What this block does
// - Type from memory, interface, sync fields jointly
// - Address base 01, or 00 for card
// - Address split 1001, or 1000 for card
// - Latch timing 11 when latch fitted
// - Latch strobe width 1 for synchronous
// - Prefer low-order addressing code 011
// - Program fields in order, sync enable last
// - Device may hold ready low forever
// - Sync bursts up to 32 bytes, consecutive
// - Latches capture 26-bit card address
module smbc_host #(
  parameter int WDOG_W  = 16,
  parameter int NUM_CS  = 4
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Software port
  input  wire logic [7:0]           sw_addr,
  input  wire logic [31:0]          sw_wdata,
  input  wire logic                 sw_wr,
  input  wire logic                 sw_rd,
  output logic      [31:0]          sw_rdata,
  // Device configuration port
  output smbc_pkg::smbc_cfg_wr_t    dev_cfg,
  input  wire logic [NUM_CS-1:0]    cs_active,
  // Transfer watchdog
  input  wire logic                 xfer_busy,
  output logic                      wdog_reset_req
);
  import smbc_pkg::*;

  initial
  begin
    if (NUM_CS != 4 || WDOG_W < 2 || WDOG_W > 32)
      $error("smbc_host: unsupported parameters");
  end

  function automatic logic is_sync(input logic [2:0] iface);
    return iface == `SMBC_IFACE_SYNC;
  endfunction

  function automatic logic [7:0] field_value(
    input smbc_field_t  f,
    input smbc_if_cfg_t ic,
    input smbc_timing_t tc
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (f)
      F_IFACE:   v = {5'h00, ic.iface};
      F_BASE:    v = ic.cf_card ? `SMBC_BASE_CF : `SMBC_BASE_16;
      // The split decides how the card's latched address is formed
      F_SPLIT:   v = ic.cf_card ? `SMBC_SPLIT_CF
                                : `SMBC_SPLIT_16;
      F_ALT:     v = {6'h00, ic.latch_setup_hold_field};
      F_ALW:     v = is_sync(ic.iface) ? `SMBC_ALW_SYNC
                                       : {6'h00, ic.latch_strobe_width_field};
      F_SCHEME:  v = {5'h00, ic.scheme};
      F_MEMTYPE: v = {5'h00, ic.mem_type};
      F_FIRST:   v = tc.first_delay;
      F_NEXT:    v = tc.next_delay;
      F_SYNC_RD: v = {4'h0, tc.sync_rd_lat};
      F_SYNC_WR: v = {4'h0, tc.sync_wr_lat};
      F_SYNC_EN: v = {7'h00, is_sync(ic.iface)};
      default:   v = 8'h00;
    endcase
    return v;
  endfunction

  // Software-visible registers
  smbc_if_cfg_t  ic_q, ic_d;
  smbc_timing_t  tc_q, tc_d;
  logic [5:0]    burst_q, burst_d;
  logic [WDOG_W-1:0] limit_q, limit_d;
  logic [1:0]    sel_q, sel_d;
  logic          done_q, done_d;
  logic          fired_q, fired_d;
  logic          err_q, err_d;
  logic [31:0]   rdata_d;

  // Sequencer state
  smbc_state_t   st_q, st_d;
  smbc_field_t   step_q, step_d;
  smbc_if_cfg_t  lat_ic_q, lat_ic_d;
  smbc_timing_t  lat_tc_q, lat_tc_d;
  smbc_cfg_wr_t  cfg_d;

  logic          start;
  logic          arm;
  logic          clr;
  logic          bad_cfg;
  logic          shadow_wr;
  logic [31:0]   shadow_rd;
  logic          wd_fire;

  assign start = sw_wr && sw_addr == `SMBC_OFF_CTRL
                 && sw_wdata[`SMBC_CTRL_START];
  assign arm   = sw_wr && sw_addr == `SMBC_OFF_CTRL
                 && sw_wdata[`SMBC_CTRL_ARM];
  assign clr   = sw_wr && sw_addr == `SMBC_OFF_CTRL
                 && sw_wdata[`SMBC_CTRL_CLR];

  // A sync flag disagreeing with the interface type is refused
  always_comb
  begin
    bad_cfg = (ic_q.sync_en != is_sync(ic_q.iface))
              || (is_sync(ic_q.iface)
                  && burst_q > `SMBC_BURST_MAX);
  end

  always_comb
  begin
    ic_d    = ic_q;
    tc_d    = tc_q;
    burst_d = burst_q;
    limit_d = limit_q;
    sel_d   = sel_q;
    if (sw_wr)
    begin
      unique case (sw_addr)
        `SMBC_OFF_IFCFG:  ic_d    = sw_wdata[$bits(smbc_if_cfg_t)-1:0];
        `SMBC_OFF_TIMING: tc_d    = sw_wdata[$bits(smbc_timing_t)-1:0];
        `SMBC_OFF_BURST:  burst_d = sw_wdata[5:0];
        `SMBC_OFF_WDOG:   limit_d = sw_wdata[WDOG_W-1:0];
        `SMBC_OFF_CTRL:
        begin
          if (st_q == S_IDLE)
            sel_d = sw_wdata[`SMBC_CTRL_SEL +: 2];
        end
        default:;
      endcase
    end
  end

  // Sticky flags: a hardware set wins over a software clear
  always_comb
  begin
    done_d  = clr ? 1'b0 : done_q;
    fired_d = clr ? 1'b0 : fired_q;
    err_d   = clr ? 1'b0 : err_q;
    if (st_q == S_DONE)
      done_d = 1'b1;
    if (wd_fire)
      fired_d = 1'b1;
    if (start && st_q == S_IDLE && bad_cfg)
      err_d = 1'b1;
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (sw_rd)
    begin
      unique case (sw_addr)
        `SMBC_OFF_CTRL:   rdata_d = {26'h0, sel_q, fired_q, err_q,
                                     done_q, st_q != S_IDLE};
        `SMBC_OFF_IFCFG:  rdata_d = {17'h0, ic_q};
        `SMBC_OFF_TIMING: rdata_d = {8'h00, tc_q};
        `SMBC_OFF_BURST:  rdata_d = {26'h0, burst_q};
        `SMBC_OFF_WDOG:   rdata_d = 32'(limit_q);
        `SMBC_OFF_SHADOW: rdata_d = shadow_rd;
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Sequencer: snapshot the settings, wait for a quiet chip select,
  // then write each field in the fixed order
  always_comb
  begin
    st_d     = st_q;
    step_d   = step_q;
    lat_ic_d = lat_ic_q;
    lat_tc_d = lat_tc_q;
    cfg_d    = dev_cfg;
    cfg_d.wr = 1'b0;
    unique case (st_q)
      S_IDLE:
      begin
        if (start && !bad_cfg)
        begin
          lat_ic_d = ic_q;
          lat_tc_d = tc_q;
          step_d   = F_IFACE;
          st_d     = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (!cs_active[sel_q])
          st_d = S_WRITE;
      end
      S_WRITE:
      begin
        cfg_d.wr    = 1'b1;
        cfg_d.cs    = sel_q;
        cfg_d.field = step_q;
        cfg_d.value = field_value(step_q, lat_ic_q, lat_tc_q);
        st_d        = S_GAP;
      end
      S_GAP:
      begin
        if (step_q == F_SYNC_EN)
          st_d = S_DONE;
        else
        begin
          step_d = smbc_field_t'(step_q + 4'h1);
          st_d   = S_WRITE;
        end
      end
      S_DONE:
        st_d = S_IDLE;
      default:
        st_d = S_IDLE;
    endcase
  end

  assign shadow_wr = (st_q == S_DONE);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ic_q     <= '{iface: 3'h0, mem_type: 3'h0, sync_en: 1'b0,
                    cf_card: 1'b0, latch_setup_hold_field: `SMBC_RST_ALT,
                    latch_strobe_width_field: `SMBC_RST_ALW,
                    scheme: `SMBC_RST_SCHEME};
      tc_q     <= '0;
      burst_q  <= 6'h00;
      limit_q  <= WDOG_W'(`SMBC_RST_WDOG);
      sel_q    <= 2'h0;
      done_q   <= 1'b0;
      fired_q  <= 1'b0;
      err_q    <= 1'b0;
      sw_rdata <= 32'h0000_0000;
      st_q     <= S_IDLE;
      step_q   <= F_IFACE;
      lat_ic_q <= '0;
      lat_tc_q <= '0;
      dev_cfg  <= '{wr: 1'b0, cs: 2'h0, field: F_IFACE, value: 8'h00};
    end
    else
    begin
      ic_q     <= ic_d;
      tc_q     <= tc_d;
      burst_q  <= burst_d;
      limit_q  <= limit_d;
      sel_q    <= sel_d;
      done_q   <= done_d;
      fired_q  <= fired_d;
      err_q    <= err_d;
      sw_rdata <= rdata_d;
      st_q     <= st_d;
      step_q   <= step_d;
      lat_ic_q <= lat_ic_d;
      lat_tc_q <= lat_tc_d;
      dev_cfg  <= cfg_d;
    end
  end

  smbc_shadow_mem #(
    .WIDTH (32),
    .DEPTH (NUM_CS)
  ) u_shadow (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (shadow_wr),
    .wr_addr (sel_q),
    .wr_data ({17'h0, lat_ic_q}),
    .rd_addr (sel_q),
    .rd_data (shadow_rd)
  );

  smbc_wdog #(
    .WIDTH (WDOG_W)
  ) u_wdog (
    .mclk      (mclk),
    .rst       (rst),
    .arm       (arm),
    .limit     (limit_q),
    .xfer_busy (xfer_busy),
    .fire      (wd_fire)
  );

  assign wdog_reset_req = wd_fire;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_order;
    dev_cfg.wr && dev_cfg.field != F_SYNC_EN |-> ##2
      (dev_cfg.wr && dev_cfg.field ==
       smbc_field_t'($past(dev_cfg.field, 2) + 4'h1));
  endproperty
  a_order: assert property (p_order)
    else $error("field order broken");

  property p_sxen_last;
    dev_cfg.wr && dev_cfg.field == F_SYNC_EN |-> ##1 !dev_cfg.wr
      ##1 (!dev_cfg.wr && done_q);
  endproperty
  a_sxen_last: assert property (p_sxen_last)
    else $error("sync enable not last");

  property p_base;
    dev_cfg.wr && dev_cfg.field == F_BASE |->
      dev_cfg.value == (lat_ic_q.cf_card ? 8'h00 : 8'h01);
  endproperty
  a_base: assert property (p_base)
    else $error("address base wrong");

  property p_split;
    dev_cfg.wr && dev_cfg.field == F_SPLIT |->
      dev_cfg.value == (lat_ic_q.cf_card ? 8'h08 : 8'h09);
  endproperty
  a_split: assert property (p_split)
    else $error("address split wrong");

  property p_alw_sync;
    dev_cfg.wr && dev_cfg.field == F_ALW
      && lat_ic_q.iface == `SMBC_IFACE_SYNC |-> dev_cfg.value == 8'h01;
  endproperty
  a_alw_sync: assert property (p_alw_sync)
    else $error("latch width not 1 for sync");

  property p_joint;
    dev_cfg.wr && dev_cfg.field == F_SYNC_EN |->
      dev_cfg.value[0] == lat_ic_q.sync_en
      && dev_cfg.value[0] == (lat_ic_q.iface == `SMBC_IFACE_SYNC);
  endproperty
  a_joint: assert property (p_joint)
    else $error("sync enable disagrees with type");

  property p_burst;
    start && st_q == S_IDLE && ic_q.iface == `SMBC_IFACE_SYNC
      && burst_q > 6'h20 |=> err_q && st_q == S_IDLE;
  endproperty
  a_burst: assert property (p_burst)
    else $error("long burst not refused");

  property p_alt_reset;
    $fell(rst) |-> ic_q.latch_setup_hold_field == 2'h3;
  endproperty
  a_alt_reset: assert property (p_alt_reset)
    else $error("latch timing reset wrong");

  property p_scheme_reset;
    $fell(rst) |-> ic_q.scheme == 3'h3;
  endproperty
  a_scheme_reset: assert property (p_scheme_reset)
    else $error("addressing reset wrong");

  c_full: cover property (dev_cfg.wr && dev_cfg.field == F_SYNC_EN);
  c_card: cover property (dev_cfg.wr && dev_cfg.field == F_SPLIT
                          && dev_cfg.value == 8'h08);
  c_fire: cover property (wd_fire);
  c_wait: cover property (st_q == S_WAIT [*3]);
endmodule

/* File: verif/smbc_dev_model.sv */
`timescale 1ns/10ps
module smbc_dev_model
  import smbc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Configuration writes from the host
  input  smbc_pkg::smbc_cfg_wr_t dev_cfg,
  // Bench controls
  input  wire logic [3:0]        hold_cs,
  input  wire logic              xfer_go,
  // Activity seen by the host
  output logic      [3:0]        cs_active,
  output logic                   xfer_busy,
  // What the device latched
  output logic      [7:0]        got [0:11],
  output logic      [1:0]        got_cs,
  output logic      [3:0]        nxt_q,
  output logic                   viol_q,
  output int                     wr_cnt
);
  logic rdy_meta_q;
  logic rdy_sync_q;

  assign cs_active = hold_cs;

  // Ready is low while the bench holds an access open
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdy_meta_q <= 1'b1;
      rdy_sync_q <= 1'b1;
    end
    else
    begin
      rdy_meta_q <= !xfer_go;
      rdy_sync_q <= rdy_meta_q;
    end
  end

  // Wait states last while synchronised ready is low, with no timeout
  assign xfer_busy = !rdy_sync_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      nxt_q  <= 4'h0;
      viol_q <= 1'b0;
      wr_cnt <= 0;
    end
    else if (dev_cfg.wr)
    begin
      wr_cnt <= wr_cnt + 1;
      if (dev_cfg.field != smbc_field_t'(nxt_q))
        viol_q <= 1'b1;
      if (cs_active[dev_cfg.cs])
        viol_q <= 1'b1;
      if (nxt_q != 4'h0 && dev_cfg.cs != got_cs)
        viol_q <= 1'b1;
      got[dev_cfg.field] <= dev_cfg.value;
      got_cs <= dev_cfg.cs;
      nxt_q  <= (dev_cfg.field == F_SYNC_EN) ? 4'h0 : nxt_q + 4'h1;
    end
  end
endmodule

/* File: verif/tb_static_memory_bus_controller.sv */
`timescale 1ns/10ps
`include "smbc_cfg.svh"
module tb_static_memory_bus_controller;
  import smbc_pkg::*;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   sw_addr = 8'h00;
  logic [31:0]  sw_wdata = 32'h0;
  logic         sw_wr = 1'b0;
  logic         sw_rd = 1'b0;
  logic [31:0]  sw_rdata;
  smbc_cfg_wr_t dev_cfg;
  logic [3:0]   cs_active;
  logic         xfer_busy;
  logic         wdog_reset_req;
  logic [3:0]   hold_cs = 4'h0;
  logic         xfer_go = 1'b0;
  logic [7:0]   got [0:11];
  logic [1:0]   got_cs;
  logic [3:0]   nxt_q;
  logic         viol_q;
  int           wr_cnt;
  int           errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  int           fires = 0;
  integer       seed = 32'hcc665a37;
  logic [31:0]  rd;
  logic [31:0]  r;

  always #50 mclk = ~mclk;

  smbc_host i_smbc_host (.mclk(mclk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .dev_cfg(dev_cfg), .cs_active(cs_active), .xfer_busy(xfer_busy),
    .wdog_reset_req(wdog_reset_req));

  smbc_dev_model i_smbc_dev_model (.mclk(mclk), .rst(rst), .dev_cfg(dev_cfg),
    .hold_cs(hold_cs), .xfer_go(xfer_go), .cs_active(cs_active),
    .xfer_busy(xfer_busy), .got(got), .got_cs(got_cs), .nxt_q(nxt_q),
    .viol_q(viol_q), .wr_cnt(wr_cnt));

  task automatic test_done;
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hung sequencer must not stall the run forever
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (wdog_reset_req === 1'b1)
      fires = fires + 1;
    if (cyc == 30000)
    begin
      errors = errors + 1;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge mclk);
    sw_wr    <= 1'b0;
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge mclk);
    sw_rd   <= 1'b0;
    // Data stand for the cycle after the strobe; take them at its end
    @(posedge mclk);
    d = sw_rdata;
  endtask

  function automatic logic [7:0] exp_val(int i, logic [14:0] ic,
                                         logic [23:0] tc);
    case (i)
      0:       return {5'h0, ic[14:12]};
      1:       return ic[7] ? 8'h00 : 8'h01;
      2:       return ic[7] ? 8'h08 : 8'h09;
      3:       return {6'h0, ic[6:5]};
      4:       return (ic[14:12] == 3'h4) ? 8'h01 : {6'h0, ic[4:3]};
      5:       return {5'h0, ic[2:0]};
      6:       return {5'h0, ic[11:9]};
      7:       return tc[23:16];
      8:       return tc[15:8];
      9:       return {4'h0, tc[7:4]};
      10:      return {4'h0, tc[3:0]};
      default: return {7'h0, ic[14:12] == 3'h4};
    endcase
  endfunction

  task automatic run_cfg(input logic [1:0] cs, input logic [14:0] ic,
                         input logic [23:0] tc, input logic [5:0] bst,
                         input logic hold, input logic bad);
    int n0;
    n0 = wr_cnt;
    sw_write(`SMBC_OFF_IFCFG, {17'h0, ic});
    sw_write(`SMBC_OFF_TIMING, {8'h0, tc});
    sw_write(`SMBC_OFF_BURST, {26'h0, bst});
    sw_write(`SMBC_OFF_CTRL, {29'h0, cs, 1'b0});
    hold_cs[cs] <= hold;
    sw_write(`SMBC_OFF_CTRL, {29'h0, cs, 1'b1});
    if (hold)
    begin
      repeat (40) @(posedge mclk);
      sw_read(`SMBC_OFF_CTRL, rd);
      chk("busy while cs active", 32'h1, {31'h0, rd[0]});
      chk("writes while cs active", n0, wr_cnt);
      hold_cs[cs] <= 1'b0;
    end
    for (int k = 0; k < 30; k++)
    begin
      sw_read(`SMBC_OFF_CTRL, rd);
      if (rd[0] === 1'b0)
        break;
    end
    chk("ctrl done/err", bad ? 32'h4 : 32'h2, {29'h0, rd[2:0]});
    if (bad)
      chk("no writes on bad cfg", n0, wr_cnt);
    else
    begin
      for (int i = 0; i < 12; i++)
        chk("field", exp_val(i, ic, tc), got[i]);
      chk("cs", cs, got_cs);
      chk("order", 0, {nxt_q, viol_q});
      sw_read(`SMBC_OFF_SHADOW, rd);
      chk("shadow", ic, rd);
    end
    sw_write(`SMBC_OFF_CTRL, {27'h0, 1'b1, 1'b0, cs, 1'b0});
  endtask

  initial
  begin
    logic [31:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [31:0] rstv [7] = '{0, 32'h6B, 0, 0, 32'hFFFF, 0, 0};
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      sw_read(offs[i][7:0], rd);
      chk("reset value", rstv[i], rd);
    end
    // Card, synchronous, largest burst, back-pressured by an active cs
    run_cfg(2'h2, {3'h4, 3'h1, 1'b1, 1'b1, 2'h3, 2'h2, 3'h3}, 24'h12345A,
            6'h20, 1'b1, 1'b0);
    for (int n = 0; n < 8; n++)
    begin
      r = $random(seed);
      run_cfg(r[17:16], {r[14:9], r[14:12] == 3'h4, r[7:0]}, $random(seed),
              (r[14:12] == 3'h4) ? {1'b0, r[22:18]} : r[23:18], 1'b0, 1'b0);
    end
    run_cfg(2'h1, 15'h0100, 24'h0, 6'h0, 1'b0, 1'b1);
    run_cfg(2'h3, 15'h4100, 24'h0, 6'h21, 1'b0, 1'b1);
    // Watchdog on a transfer that never finishes
    xfer_go <= 1'b1;
    sw_write(`SMBC_OFF_WDOG, 32'h8);
    sw_write(`SMBC_OFF_CTRL, 32'h8);
    for (int k = 1; k < 40; k++)
    begin
      @(posedge mclk);
      #1;
      if (wdog_reset_req === 1'b1)
      begin
        chk("wdog delay", 9, k);
        break;
      end
    end
    sw_read(`SMBC_OFF_CTRL, rd);
    chk("wdog flag", 32'h1, {31'h0, rd[3]});
    xfer_go <= 1'b0;
    sw_write(`SMBC_OFF_CTRL, 32'h10);
    // Transfer ends before the limit: no reset request
    xfer_go <= 1'b1;
    sw_write(`SMBC_OFF_CTRL, 32'h8);
    repeat (4) @(posedge mclk);
    xfer_go <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("wdog pulses", 1, fires);
    sw_read(`SMBC_OFF_CTRL, rd);
    chk("flags cleared", 32'h0, {31'h0, rd[3]});
    test_done;
  end
endmodule
